// file: hw/fbep_flash_ctrl.v
// Flash array with erase units, per-region protection and single-cycle reads.
// Assumes requesters hold one request per cycle and honour the pulse outputs.
// What this block does
// - 128 KB array, 1 KB units erased alone
// - Erased unit reads back all ones
// - Protection per 2 KB region, independent
// - Levels: none, read-only, execute-only
// - Read-only refuses erase and program, reads allowed
// - Execute-only refuses erase and program
// - Execute-only serves instruction fetch only
// - Permitted read answers in one cycle
`timescale 1ns/1ps
`default_nettype none
`include "fbep_defs.vh"

module fbep_flash_ctrl
#(
    parameter REGIONS = 64
)
(
    input  wire                     ref_clk,
    input  wire                     resetn,
    // Instruction fetch port
    input  wire                     if_req,
    input  wire [`FBEP_ADDR_W-1:0]  if_addr,
    output reg  [31:0]              if_rdata_ff,
    output reg                      if_valid_ff,
    output reg                      if_deny_ff,
    // Processor data port
    input  wire                     d_req,
    input  wire                     d_we,
    input  wire                     d_erase,
    input  wire [`FBEP_ADDR_W-1:0]  d_addr,
    input  wire [31:0]              d_wdata,
    output reg  [31:0]              d_rdata_ff,
    output reg                      d_valid_ff,
    output reg                      d_deny_ff,
    // Debugger read port
    input  wire                     dbg_req,
    input  wire [`FBEP_ADDR_W-1:0]  dbg_addr,
    output reg  [31:0]              dbg_rdata_ff,
    output reg                      dbg_valid_ff,
    output reg                      dbg_deny_ff,
    // Protection setting per region
    input  wire                     prot_we,
    input  wire [`FBEP_REGION_W-1:0] prot_region,
    input  wire [1:0]               prot_level,
    output reg  [2*REGIONS-1:0]     prot_tbl_ff,
    // Sticky violation flag, cleared by software
    input  wire                     viol_clr,
    output reg                      viol_ff,
    output reg                      erase_busy_ff
);

    localparam WORDS = 1 << `FBEP_WORD_AW;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    reg rst_s1_ff;
    reg rst_n_ff;
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s1_ff <= 1'b0;
            rst_n_ff  <= 1'b0;
        end
        else
        begin
            rst_s1_ff <= 1'b1;
            rst_n_ff  <= rst_s1_ff;
        end
    end

    // ----------------------------------------
    // Array storage
    // ----------------------------------------
    reg [31:0] mem [0:WORDS-1];

    function [`FBEP_WORD_AW-1:0] widx;
        input [`FBEP_ADDR_W-1:0] a;
        begin
            widx = a[`FBEP_ADDR_W-1:2];
        end
    endfunction

    // ----------------------------------------
    // Protection checks, one per port
    // ----------------------------------------
    wire       if_ok;
    wire       d_ok;
    wire       dbg_ok;
    wire [2:0] d_kind = d_erase ? `FBEP_RQ_ERASE : (d_we ? `FBEP_RQ_PROG : `FBEP_RQ_DREAD);

    fbep_prot_check #(.REGIONS(REGIONS)) u_chk_if
    (
        .prot_tbl (prot_tbl_ff),
        .addr     (if_addr),
        .kind     (`FBEP_RQ_FETCH),
        .allow    (if_ok)
    );
    fbep_prot_check #(.REGIONS(REGIONS)) u_chk_d
    (
        .prot_tbl (prot_tbl_ff),
        .addr     (d_addr),
        .kind     (d_kind),
        .allow    (d_ok)
    );
    fbep_prot_check #(.REGIONS(REGIONS)) u_chk_dbg
    (
        .prot_tbl (prot_tbl_ff),
        .addr     (dbg_addr),
        .kind     (`FBEP_RQ_DBG),
        .allow    (dbg_ok)
    );

    // ----------------------------------------
    // Erase sequencer states
    // ----------------------------------------
    localparam ST_IDLE  = 2'b01;
    localparam ST_ERASE = 2'b10;

    reg [1:0]                  state_ff;
    reg [1:0]                  nxt_state;
    reg [`FBEP_UNIT_W-1:0]     eunit_ff;
    reg [7:0]                  ecnt_ff;
    wire erase_go = d_req && d_erase && d_ok && (state_ff == ST_IDLE);
    wire erase_end = (state_ff == ST_ERASE) && (ecnt_ff == 8'hFF);

    always @*
    begin
        case (state_ff)
            ST_IDLE:  nxt_state = erase_go ? ST_ERASE : ST_IDLE;
            ST_ERASE: nxt_state = erase_end ? ST_IDLE : ST_ERASE;
            default:  nxt_state = ST_IDLE;
        endcase
    end

    // Erase walks one word per cycle; other units stay untouched
    always @(posedge ref_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            state_ff      <= ST_IDLE;
            eunit_ff      <= {`FBEP_UNIT_W{1'b0}};
            ecnt_ff       <= 8'h00;
            erase_busy_ff <= 1'b0;
        end
        else
        begin
            state_ff      <= nxt_state;
            erase_busy_ff <= (nxt_state == ST_ERASE);
            if (erase_go)
            begin
                eunit_ff <= d_addr[`FBEP_ADDR_W-1:`FBEP_UNIT_LSB];
                ecnt_ff  <= 8'h00;
            end
            else if (state_ff == ST_ERASE)
                ecnt_ff <= ecnt_ff + 8'h01;
        end
    end

    // ----------------------------------------
    // Array writes: erase fill or permitted program
    // ----------------------------------------
    wire prog_go = d_req && d_we && !d_erase && d_ok && (state_ff == ST_IDLE);

    // No reset on storage; contents survive like real flash
    always @(posedge ref_clk)
    begin
        if (state_ff == ST_ERASE)
            mem[{eunit_ff, ecnt_ff}] <= `FBEP_ERASED_WORD;
        else if (prog_go)
            mem[widx(d_addr)] <= mem[widx(d_addr)] & d_wdata;
    end

    // ----------------------------------------
    // Read answers, one cycle after request
    // ----------------------------------------
    // Reads are refused while an erase runs, reported as denied
    wire busy = (state_ff != ST_IDLE);
    wire d_rd = d_req && !d_we && !d_erase;

    always @(posedge ref_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            if_rdata_ff  <= 32'h00000000;
            if_valid_ff  <= 1'b0;
            if_deny_ff   <= 1'b0;
            d_rdata_ff   <= 32'h00000000;
            d_valid_ff   <= 1'b0;
            d_deny_ff    <= 1'b0;
            dbg_rdata_ff <= 32'h00000000;
            dbg_valid_ff <= 1'b0;
            dbg_deny_ff  <= 1'b0;
        end
        else
        begin
            if_valid_ff  <= if_req && if_ok && !busy;
            if_deny_ff   <= if_req && (!if_ok || busy);
            if_rdata_ff  <= (if_req && if_ok && !busy) ? mem[widx(if_addr)] : 32'h00000000;
            d_valid_ff   <= d_req && d_ok && !busy;
            d_deny_ff    <= d_req && (!d_ok || busy);
            d_rdata_ff   <= (d_rd && d_ok && !busy) ? mem[widx(d_addr)] : 32'h00000000;
            dbg_valid_ff <= dbg_req && dbg_ok && !busy;
            dbg_deny_ff  <= dbg_req && (!dbg_ok || busy);
            dbg_rdata_ff <= (dbg_req && dbg_ok && !busy) ? mem[widx(dbg_addr)] : 32'h00000000;
        end
    end

    // ----------------------------------------
    // Protection table and violation flag
    // ----------------------------------------
    wire viol_evt = (if_req && !if_ok) || (d_req && !d_ok) || (dbg_req && !dbg_ok);

    always @(posedge ref_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            prot_tbl_ff <= {2*REGIONS{1'b0}};
            viol_ff     <= 1'b0;
        end
        else
        begin
            if (prot_we)
                prot_tbl_ff[{prot_region, 1'b0} +: 2] <= prot_level;
            // Set wins over a same-cycle clear
            viol_ff <= viol_evt | (viol_ff & ~viol_clr);
        end
    end

endmodule
`default_nettype wire

// file: hw/fbep_defs.vh
// Constants for the flash access and protection block.
// Assumes byte addressing into a 128 KB array, 32-bit words.
`ifndef FBEP_DEFS_VH
`define FBEP_DEFS_VH

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define FBEP_ADDR_W       17
`define FBEP_WORD_AW      15
`define FBEP_UNIT_LSB     10
`define FBEP_UNIT_W       7
`define FBEP_REGION_LSB   11
`define FBEP_REGION_W     6
`define FBEP_UNIT_WORDS   256
`define FBEP_ERASED_WORD  32'hFFFFFFFF

// ----------------------------------------
// Protection levels
// ----------------------------------------
`define FBEP_PROT_NONE    2'h0
`define FBEP_PROT_RO      2'h1
`define FBEP_PROT_XO      2'h2

// ----------------------------------------
// Request kinds seen by the array
// ----------------------------------------
`define FBEP_RQ_FETCH     3'h0
`define FBEP_RQ_DREAD     3'h1
`define FBEP_RQ_DBG       3'h2
`define FBEP_RQ_PROG      3'h3
`define FBEP_RQ_ERASE     3'h4

`endif

// file: hw/fbep_prot_check.v
// Protection decision for one request against a per-region level table.
// Assumes the table is held by the caller; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "fbep_defs.vh"

module fbep_prot_check
#(
    parameter REGIONS = 64
)
(
    input  wire [2*REGIONS-1:0]     prot_tbl,
    input  wire [`FBEP_ADDR_W-1:0]  addr,
    input  wire [2:0]               kind,
    output reg                      allow
);

    // ----------------------------------------
    // Region lookup and permission
    // ----------------------------------------
    wire [`FBEP_REGION_W-1:0] region = addr[`FBEP_ADDR_W-1:`FBEP_REGION_LSB];
    wire [1:0]                level  = prot_tbl[{region, 1'b0} +: 2];

    // Undefined level code treated as unprotected
    always @*
    begin
        allow = 1'b1;
        case (level)
            `FBEP_PROT_RO:
                allow = (kind != `FBEP_RQ_PROG) && (kind != `FBEP_RQ_ERASE);
            `FBEP_PROT_XO:
                allow = (kind == `FBEP_RQ_FETCH);
            default:
                allow = 1'b1;
        endcase
    end

endmodule
`default_nettype wire

// file: sim/fbep_monitor.sv
// Port checker for the flash access block, bound into its top.
// Assumes requests start only once the reset synchroniser lets go.
`timescale 1ns/1ps
`default_nettype none
module fbep_monitor
#(
    parameter REGIONS = 64
)
(
    input wire                 ref_clk,
    input wire                 resetn,
    input wire                 viol_clr,
    input wire                 viol_ff,
    input wire                 erase_busy_ff,
    input wire                 if_req,
    input wire                 if_valid_ff,
    input wire                 if_deny_ff,
    input wire                 dbg_req,
    input wire                 dbg_valid_ff,
    input wire                 dbg_deny_ff,
    input wire                 d_req,
    input wire                 d_we,
    input wire                 d_erase,
    input wire                 d_valid_ff,
    input wire                 d_deny_ff,
    input wire [16:0]          if_addr,
    input wire [16:0]          d_addr,
    input wire [16:0]          dbg_addr,
    input wire [2*REGIONS-1:0] prot_tbl_ff
);
    // Level of the region each port points at
    wire [1:0] lv_i = prot_tbl_ff[{if_addr[16:11], 1'b0} +: 2];
    wire [1:0] lv_d = prot_tbl_ff[{d_addr[16:11], 1'b0} +: 2];
    wire [1:0] lv_b = prot_tbl_ff[{dbg_addr[16:11], 1'b0} +: 2];
    // Busy refusals carry no flag, so each protection check excludes them
    wire go_d = d_req && !erase_busy_ff;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    property p_if_ans; if_req |=> if_valid_ff ^ if_deny_ff; endproperty
    a_if_ans: assert property (p_if_ans) else $error("fetch unanswered");
    property p_d_ans; d_req |=> d_valid_ff ^ d_deny_ff; endproperty
    a_d_ans: assert property (p_d_ans) else $error("data unanswered");
    property p_xo_d; go_d && lv_d == 2'h2 |=> d_deny_ff && viol_ff; endproperty
    a_xo_d: assert property (p_xo_d) else $error("exec-only data served");
    property p_xo_b; dbg_req && !erase_busy_ff && lv_b == 2'h2 |=> dbg_deny_ff; endproperty
    a_xo_b: assert property (p_xo_b) else $error("exec-only debug served");
    property p_xo_i; if_req && !erase_busy_ff && lv_i == 2'h2 |=> if_valid_ff; endproperty
    a_xo_i: assert property (p_xo_i) else $error("fetch refused");
    property p_ro; go_d && (d_we || d_erase) && lv_d == 2'h1 |=> d_deny_ff; endproperty
    a_ro: assert property (p_ro) else $error("read-only modified");
    // Levels 0 and 3 both mean open
    property p_open; go_d && lv_d[0] == lv_d[1] |=> d_valid_ff; endproperty
    a_open: assert property (p_open) else $error("open region refused");
    property p_erase; go_d && d_erase && lv_d[0] == lv_d[1]
        |=> erase_busy_ff ##255 erase_busy_ff ##1 !erase_busy_ff; endproperty
    a_erase: assert property (p_erase) else $error("erase window wrong");
    property p_viol; viol_ff && !viol_clr |=> viol_ff; endproperty
    a_viol: assert property (p_viol) else $error("flag dropped");
endmodule
bind fbep_flash_ctrl fbep_monitor #(.REGIONS(REGIONS)) u_mon (.ref_clk, .resetn,
    .viol_clr, .viol_ff, .erase_busy_ff, .if_req, .if_valid_ff, .if_deny_ff, .dbg_req,
    .dbg_valid_ff, .dbg_deny_ff, .d_req, .d_we, .d_erase, .d_valid_ff, .d_deny_ff,
    .if_addr, .d_addr, .dbg_addr, .prot_tbl_ff);
`default_nettype wire

// file: sim/fbep_host_model.sv
// Requester model: fetch, data and debug ports of the flash block.
// Assumes the bench presents one request kind at a time with go.
`timescale 1ns/1ps
`default_nettype none
`include "fbep_defs.vh"
module fbep_host_model
(
    input  wire       go,
    input  wire [2:0] kind,
    output wire       if_req,
    output wire       d_req,
    output wire       d_we,
    output wire       d_erase,
    output wire       dbg_req
);
    // One port lit per request; program and erase share the data port
    assign if_req  = go && kind == `FBEP_RQ_FETCH;
    assign dbg_req = go && kind == `FBEP_RQ_DBG;
    assign d_we    = kind == `FBEP_RQ_PROG;
    assign d_erase = kind == `FBEP_RQ_ERASE;
    assign d_req   = go && !if_req && !dbg_req;
endmodule
`default_nettype wire

// file: sim/flash_block_erase_protect_bench.sv
// Self-checking bench for the flash access block.
// Assumes a 50 MHz ref_clk; inputs move on falling edges only.
`timescale 1ns/1ps
`default_nettype none
module flash_block_erase_protect_bench;
    reg ref_clk = 0, resetn = 0, go = 0, pwe = 0, vclr = 0, ok;
    reg [2:0] k = 0;
    reg [16:0] a = 0;
    reg [31:0] wd = 0;
    reg [5:0] preg = 0;
    reg [1:0] plv = 0;
    // Row: ok bit and kind in one nibble, byte address, data
    reg [55:0] row [0:13];
    wire ifr, dr, dwe, der, br, iv, idn, dv, ddn, bv, bdn, viol, busy;
    wire [31:0] ird, drd, brd;
    wire [127:0] tbl;
    integer fail_count = 0, n_tests = 0, i, n;
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    fbep_host_model u_host (.go(go), .kind(k), .if_req(ifr), .d_req(dr), .d_we(dwe),
        .d_erase(der), .dbg_req(br));
    fbep_flash_ctrl #(.REGIONS(64)) u_dut (.ref_clk(ref_clk), .resetn(resetn),
        .if_req(ifr), .if_addr(a), .if_rdata_ff(ird), .if_valid_ff(iv), .if_deny_ff(idn),
        .d_req(dr), .d_we(dwe), .d_erase(der), .d_addr(a), .d_wdata(wd), .d_rdata_ff(drd),
        .d_valid_ff(dv), .d_deny_ff(ddn), .dbg_req(br), .dbg_addr(a), .dbg_rdata_ff(brd),
        .dbg_valid_ff(bv), .dbg_deny_ff(bdn), .prot_we(pwe), .prot_region(preg),
        .prot_level(plv), .prot_tbl_ff(tbl), .viol_clr(vclr), .viol_ff(viol),
        .erase_busy_ff(busy));
    task chk(input c, input [63:0] m);
    begin
        n_tests = n_tests + 1;
        if (!c)
        begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t %0s", $time, m);
        end
    end
    endtask
    task test_done;
    begin
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    // One request, answer checked a cycle later, then the flag cleared
    task op(input [55:0] r, input ev);
    begin
        {ok, k} = r[55:52];
        a = r[48:32];
        wd = r[31:0];
        go = 1;
        @(negedge ref_clk);
        go = 0;
        if (k == 3'h0)
            chk({iv, idn, ird} === {ok, !ok, ok ? wd : 32'h0}, "fetch");
        else if (k == 3'h2)
            chk({bv, bdn, brd} === {ok, !ok, ok ? wd : 32'h0}, "debug");
        else if (k == 3'h1)
            chk({dv, ddn, drd} === {ok, !ok, ok ? wd : 32'h0}, "read");
        else
            chk({dv, ddn} === {ok, !ok}, "modify");
        chk(viol === ev, "flag");
        vclr = ev;
        @(negedge ref_clk);
        vclr = 0;
    end
    endtask
    // Erase, a read refused while busy, then the busy window timed
    task er(input [16:0] ea);
    begin
        op({4'hC, 3'h0, ea, 32'h0}, 1'b0);
        op(56'h1_00400_00000000, 1'b0);
        n = 0;
        while (busy === 1'b1 && n < 300)
        begin
            @(negedge ref_clk);
            n = n + 1;
        end
        chk(n === 253, "busy");
        if (n == 300)
            test_done;
    end
    endtask
    task setp(input [5:0] r, input [1:0] l);
    begin
        preg = r;
        plv = l;
        pwe = 1;
        @(negedge ref_clk);
        pwe = 0;
    end
    endtask
    initial
    begin
        row[0] = 56'h9_003FC_FFFFFFFF;
        row[1] = 56'h9_00400_55AA55AA;
        row[2] = 56'hA_00800_C3C3C3C3;
        row[3] = 56'h3_00800_00000000;
        row[4] = 56'h4_00800_00000000;
        row[5] = 56'h9_00800_C3C3C3C3;
        row[6] = 56'h8_01000_A5A5A5A5;
        row[7] = 56'h1_01000_00000000;
        row[8] = 56'h2_01004_00000000;
        row[9] = 56'h3_01000_00000000;
        row[10] = 56'h4_01000_00000000;
        row[11] = 56'h8_01800_12345678;
        row[12] = 56'hB_01800_0F0F0F0F;
        row[13] = 56'h9_01800_02040608;
        repeat (3) @(negedge ref_clk);
        chk({viol, busy, iv, dv, bv, tbl} === 133'h0, "reset");
        resetn = 1;
        repeat (3) @(negedge ref_clk);
        for (i = 0; i < 5; i = i + 1)
            er(17'h400 * (i < 2 ? i : 2 * i - 2));
        op(56'hB_00400_55AA55AA, 1'b0);
        op(56'hB_00800_C3C3C3C3, 1'b0);
        op(56'hB_01000_A5A5A5A5, 1'b0);
        op(56'hB_01800_12345678, 1'b0);
        er(17'h0);
        setp(6'h1, 2'h1);
        setp(6'h2, 2'h2);
        setp(6'h3, 2'h3);
        chk(tbl === {120'h0, 8'hE4}, "table");
        for (i = 0; i < 14; i = i + 1)
            op(row[i], !row[i][55]);
        // Violation and clear in one cycle: the set must win
        @(negedge ref_clk);
        k = 3'h1;
        a = 17'h1000;
        go = 1;
        vclr = 1;
        @(negedge ref_clk);
        go = 0;
        vclr = 0;
        chk(viol === 1'b1 && ddn === 1'b1, "setwins");
        @(negedge ref_clk);
        chk(viol === 1'b1, "sticky");
        // Mid-run reset clears the flag and every region level
        resetn = 0;
        @(negedge ref_clk);
        chk({viol, busy, ddn, tbl} === 131'h0, "midreset");
        resetn = 1;
        repeat (3) @(negedge ref_clk);
        op(56'h9_01000_A5A5A5A5, 1'b0);
        test_done;
    end
endmodule
`default_nettype wire
